// >>> rtl/pcs_regs.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
module pcs_regs
   import pcs_pkg::*;
#(
   parameter int SAMPLE_W = 10,
   parameter logic [7:0] PART_ID = PART_ID_DEFAULT
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // buck converter controls
   output logic [1:0] io_buck_peak_limit,
   output logic io_buck_forced_mode,
   output logic [2:0] io_buck_zero_cross_level,
   output logic [1:0] core_buck_peak_limit,
   output logic core_buck_forced_mode,
   output logic [2:0] core_buck_zero_cross_level,
   output logic [1:0] core_buck_volt_sel,
   // 3.3 v regulator controls
   output logic reg33_on_n,
   output logic reg33_limit_off,
   // analog readback sources
   input wire logic sample_strobe,
   input wire logic [SAMPLE_W-1:0] red_output_batt,
   input wire logic [SAMPLE_W-1:0] green_output_batt,
   input wire logic [SAMPLE_W-1:0] blue_output_batt,
   input wire logic [SAMPLE_W-1:0] red_output_anode,
   input wire logic [SAMPLE_W-1:0] green_output_anode,
   input wire logic [SAMPLE_W-1:0] blue_output_anode,
   input wire logic temp_strobe,
   input wire logic [7:0] temp_low_in,
   input wire logic [7:0] temp_high_in,
   input wire logic [7:0] conv_status_in,
   input wire logic [7:0] dimming_in,
   input wire logic [7:0] red_headroom_in,
   input wire logic [7:0] green_headroom_in,
   input wire logic [7:0] blue_headroom_in,
   input wire logic [7:0] supply_alarm_in,
   input wire logic [7:0] driver_alarm_in,
   // interrupt
   output logic irq
);
   localparam int HW = SAMPLE_W - 8;

   logic [7:0] io_cfg_reg, io_spare_reg, core_cfg_reg, core_volt_reg;
   logic [7:0] reg33_reg;
   logic [SAMPLE_W-1:0] batt_reg [3];
   logic [SAMPLE_W-1:0] anode_reg [3];
   logic [7:0] temp_low_reg, temp_high_reg, dimming_reg;
   logic [NUM_EV-1:0] irq_status_reg, irq_mask_reg;
   logic [7:0] supply_alarm_reg, driver_alarm_reg;
   logic [7:0] rd_byte;
   logic [31:0] prdata_reg;
   logic [7:0] idx;
   logic wr_en, rd_en, mapped;
   logic [NUM_EV-1:0] ev;
   pcs_apb_state_t state_reg;

   // slave answers in the access cycle, zero wait states
   assign idx = paddr[9:2];
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = clk_en && psel && penable && pwrite && pstrb[0];
   assign rd_en = clk_en && psel && !penable && !pwrite;
   assign prdata = prdata_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= APB_IDLE;
      end else if (clk_en) begin
         case (state_reg)
            APB_IDLE: state_reg <= psel ? APB_SETUP : APB_IDLE;
            APB_SETUP: state_reg <= APB_ACCESS;
            APB_ACCESS: state_reg <= psel ? APB_SETUP : APB_IDLE;
            default: state_reg <= APB_IDLE;
         endcase
      end
   end

   // configuration registers; unmapped and read-only writes fall through
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_cfg_reg <= CFG_RESET;
         io_spare_reg <= CFG_RESET;
         core_cfg_reg <= CFG_RESET;
         core_volt_reg <= CFG_RESET;
         reg33_reg <= CFG_RESET;
         irq_mask_reg <= '0;
      end else if (wr_en) begin
         case (idx)
            IDX_IO_BUCK_CONFIG: io_cfg_reg <= pwdata[7:0] & BUCK_CFG_MASK;
            IDX_IO_BUCK_SPARE: io_spare_reg <= pwdata[7:0];
            IDX_CORE_BUCK_CONFIG:
               core_cfg_reg <= pwdata[7:0] & BUCK_CFG_MASK;
            IDX_CORE_BUCK_VOLTAGE:
               core_volt_reg <= pwdata[7:0] & CORE_VOLT_MASK;
            IDX_REG33_CONFIG: reg33_reg <= pwdata[7:0] & REG33_MASK;
            IDX_IRQ_MASK: irq_mask_reg <= pwdata[NUM_EV-1:0];
            default: ;
         endcase
      end
   end

   // field outputs
   assign io_buck_peak_limit = io_cfg_reg[PEAK_LSB +: 2];
   assign io_buck_forced_mode = io_cfg_reg[FORCED_BIT];
   assign io_buck_zero_cross_level = io_cfg_reg[ZCROSS_LSB +: 3];
   assign core_buck_peak_limit = core_cfg_reg[PEAK_LSB +: 2];
   assign core_buck_forced_mode = core_cfg_reg[FORCED_BIT];
   assign core_buck_zero_cross_level = core_cfg_reg[ZCROSS_LSB +: 3];
   assign core_buck_volt_sel = core_volt_reg[1:0];
   assign reg33_on_n = reg33_reg[REG33_ON_N_BIT];
   assign reg33_limit_off = reg33_reg[REG33_LIMIT_BIT];

   // samples latch on the strobe so low and high halves stay coherent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 3; i++) begin
            batt_reg[i] <= '0;
            anode_reg[i] <= '0;
         end
      end else if (clk_en && sample_strobe) begin
         batt_reg[0] <= red_output_batt;
         batt_reg[1] <= green_output_batt;
         batt_reg[2] <= blue_output_batt;
         anode_reg[0] <= red_output_anode;
         anode_reg[1] <= green_output_anode;
         anode_reg[2] <= blue_output_anode;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_low_reg <= '0;
         temp_high_reg <= '0;
      end else if (clk_en && temp_strobe) begin
         temp_low_reg <= temp_low_in;
         temp_high_reg <= temp_high_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dimming_reg <= DIMMING_RESET;
         supply_alarm_reg <= '0;
         driver_alarm_reg <= '0;
      end else if (clk_en) begin
         dimming_reg <= dimming_in;
         supply_alarm_reg <= supply_alarm_in;
         driver_alarm_reg <= driver_alarm_in;
      end
   end

   // sticky events; a new event beats a write-one clear in the same cycle
   assign ev[EV_SAMPLE] = sample_strobe;
   assign ev[EV_TEMP] = temp_strobe;
   assign ev[EV_SUPPLY_ALARM] = |(supply_alarm_in & ~supply_alarm_reg);
   assign ev[EV_DRIVER_ALARM] = |(driver_alarm_in & ~driver_alarm_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= '0;
      end else if (clk_en) begin
         if (wr_en && idx == IDX_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[NUM_EV-1:0]) | ev;
         end else begin
            irq_status_reg <= irq_status_reg | ev;
         end
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);

   // read mux; packed high registers put red in the low pair
   always_comb begin
      rd_byte = 8'h00;
      mapped = 1'b1;
      case (idx)
         IDX_IO_BUCK_CONFIG: rd_byte = io_cfg_reg;
         IDX_IO_BUCK_SPARE: rd_byte = io_spare_reg;
         IDX_CORE_BUCK_CONFIG: rd_byte = core_cfg_reg;
         IDX_CORE_BUCK_VOLTAGE: rd_byte = core_volt_reg;
         IDX_REG33_CONFIG: rd_byte = reg33_reg;
         IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status_reg};
         IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask_reg};
         IDX_RED_BATT_LOW: rd_byte = batt_reg[0][7:0];
         IDX_GREEN_BATT_LOW: rd_byte = batt_reg[1][7:0];
         IDX_BLUE_BATT_LOW: rd_byte = batt_reg[2][7:0];
         IDX_BATT_HIGH: rd_byte = {2'b00, batt_reg[2][SAMPLE_W-1:8],
            batt_reg[1][SAMPLE_W-1:8], batt_reg[0][SAMPLE_W-1:8]};
         IDX_RED_ANODE_LOW: rd_byte = anode_reg[0][7:0];
         IDX_GREEN_ANODE_LOW: rd_byte = anode_reg[1][7:0];
         IDX_BLUE_ANODE_LOW: rd_byte = anode_reg[2][7:0];
         IDX_ANODE_HIGH: rd_byte = {2'b00, anode_reg[2][SAMPLE_W-1:8],
            anode_reg[1][SAMPLE_W-1:8], anode_reg[0][SAMPLE_W-1:8]};
         IDX_TEMP_LOW: rd_byte = temp_low_reg;
         IDX_TEMP_HIGH: rd_byte = temp_high_reg;
         IDX_CONV_STATUS: rd_byte = {2'b00, conv_status_in[5:0]};
         IDX_DIMMING: rd_byte = dimming_reg;
         IDX_RED_HEADROOM: rd_byte = red_headroom_in;
         IDX_GREEN_HEADROOM: rd_byte = green_headroom_in;
         IDX_BLUE_HEADROOM: rd_byte = blue_headroom_in;
         IDX_PART_IDENTITY: rd_byte = PART_ID;
         IDX_SUPPLY_ALARM: rd_byte = supply_alarm_reg;
         IDX_DRIVER_ALARM: rd_byte = {driver_alarm_reg[7:4], 2'b00,
            driver_alarm_reg[1:0]};
         default: mapped = 1'b0;
      endcase
   end

   // read data captured in setup, stable through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else if (rd_en) begin
         prdata_reg <= mapped ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   sequence s_wr_reg33;
      psel && penable && pwrite && pstrb[0] && clk_en &&
         idx == IDX_REG33_CONFIG;
   endsequence

   sequence s_sample_taken;
      clk_en && sample_strobe;
   endsequence

   // a read is two steps: capture at setup, then the access that returns it
   sequence s_rd_setup;
      rd_en;
   endsequence

   sequence s_rd_access;
      clk_en && psel && penable && !pwrite;
   endsequence

   a_reg33_on_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_wr_reg33 |=> reg33_on_n == $past(pwdata[0]))
      else $error("regulator enable bit not taken");
   a_reg33_limit: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_wr_reg33 |=> reg33_limit_off == $past(pwdata[7]))
      else $error("regulator limit bit not taken");
   a_io_peak_field: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_IO_BUCK_CONFIG) |=>
      io_buck_peak_limit == $past(pwdata[5:4]))
      else $error("io buck peak field wrong");
   a_core_peak_field: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_CORE_BUCK_CONFIG) |=>
      core_buck_peak_limit == $past(pwdata[5:4]))
      else $error("core buck peak field wrong");
   a_io_forced_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_IO_BUCK_CONFIG) |=>
      io_buck_forced_mode == $past(pwdata[3]))
      else $error("io buck mode bit wrong");
   a_core_forced_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_CORE_BUCK_CONFIG) |=>
      core_buck_forced_mode == $past(pwdata[3]))
      else $error("core buck mode bit wrong");
   a_zero_cross: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_IO_BUCK_CONFIG) |=>
      io_buck_zero_cross_level == $past(pwdata[2:0]))
      else $error("zero cross field wrong");
   a_core_zero_cross: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_CORE_BUCK_CONFIG) |=>
      core_buck_zero_cross_level == $past(pwdata[2:0]))
      else $error("core zero cross field wrong");
   a_core_volt: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_CORE_BUCK_VOLTAGE) |=>
      core_volt_reg == {6'h00, $past(pwdata[1:0])})
      else $error("core voltage field wrong");
   a_volt_reset: assert property (
      @(posedge pclk) !presetn |-> core_buck_volt_sel == 2'b00)
      else $error("core voltage not reset");
   a_reg33_reset: assert property (
      @(posedge pclk) !presetn |-> !reg33_on_n && !reg33_limit_off)
      else $error("regulator not enabled in reset");
   a_batt_ro: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!(clk_en && sample_strobe)) |=> $stable(batt_reg[0]))
      else $error("battery sample changed without strobe");
   a_batt_capture: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_sample_taken |=> batt_reg[1] == $past(green_output_batt))
      else $error("battery sample not captured");
   a_batt_high_pack: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_en && idx == IDX_BATT_HIGH) |=>
      prdata[1:0] == $past(batt_reg[0][SAMPLE_W-1:8]))
      else $error("battery high bits misplaced");
   a_anode_ro: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!(clk_en && sample_strobe)) |=> $stable(anode_reg[2]))
      else $error("anode sample changed without strobe");
   a_anode_capture: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_sample_taken |=> anode_reg[0] == $past(red_output_anode))
      else $error("anode sample not captured");
   a_anode_reset: assert property (
      @(posedge pclk) !presetn |-> anode_reg[0] == {SAMPLE_W{1'b0}} &&
      anode_reg[1] == {SAMPLE_W{1'b0}} &&
      anode_reg[2] == {SAMPLE_W{1'b0}})
      else $error("anode sample not reset");
   a_unmapped_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_en && !mapped) |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_ro_write_ignored: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx > IDX_REG33_CONFIG && idx != IDX_IRQ_STATUS &&
         idx != IDX_IRQ_MASK) |=> $stable(io_cfg_reg) &&
      $stable(core_cfg_reg) && $stable(core_volt_reg) && $stable(reg33_reg))
      else $error("read-only write changed a setting");
   a_rd_upper_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_rd_setup ##1 s_rd_access |-> prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_read_stands: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_rd_setup ##1 s_rd_access |=> $stable(prdata))
      else $error("read data moved after access");
   a_apb_order: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && penable) |-> state_reg == APB_SETUP)
      else $error("access phase without setup");
   a_event_sticky: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_sample_taken |=> irq_status_reg[EV_SAMPLE])
      else $error("sample event lost");
endmodule

// >>> rtl/pcs_pkg.sv
package pcs_pkg;
   // register offsets (printed offsets are indices, byte address = 4*index)
   localparam logic [7:0] IDX_IO_BUCK_CONFIG = 8'h00;
   localparam logic [7:0] IDX_IO_BUCK_SPARE = 8'h01;
   localparam logic [7:0] IDX_CORE_BUCK_CONFIG = 8'h02;
   localparam logic [7:0] IDX_CORE_BUCK_VOLTAGE = 8'h03;
   localparam logic [7:0] IDX_REG33_CONFIG = 8'h04;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h3e;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h3f;
   localparam logic [7:0] IDX_RED_BATT_LOW = 8'h49;
   localparam logic [7:0] IDX_GREEN_BATT_LOW = 8'h4a;
   localparam logic [7:0] IDX_BLUE_BATT_LOW = 8'h4b;
   localparam logic [7:0] IDX_BATT_HIGH = 8'h4c;
   localparam logic [7:0] IDX_RED_ANODE_LOW = 8'h4d;
   localparam logic [7:0] IDX_GREEN_ANODE_LOW = 8'h4e;
   localparam logic [7:0] IDX_BLUE_ANODE_LOW = 8'h4f;
   localparam logic [7:0] IDX_ANODE_HIGH = 8'h50;
   localparam logic [7:0] IDX_TEMP_LOW = 8'h51;
   localparam logic [7:0] IDX_TEMP_HIGH = 8'h52;
   localparam logic [7:0] IDX_CONV_STATUS = 8'h53;
   localparam logic [7:0] IDX_DIMMING = 8'h54;
   localparam logic [7:0] IDX_RED_HEADROOM = 8'h55;
   localparam logic [7:0] IDX_GREEN_HEADROOM = 8'h56;
   localparam logic [7:0] IDX_BLUE_HEADROOM = 8'h57;
   localparam logic [7:0] IDX_PART_IDENTITY = 8'h60;
   localparam logic [7:0] IDX_SUPPLY_ALARM = 8'h70;
   localparam logic [7:0] IDX_DRIVER_ALARM = 8'h71;
   // field positions
   localparam int PEAK_LSB = 4;
   localparam int FORCED_BIT = 3;
   localparam int ZCROSS_LSB = 0;
   localparam int REG33_LIMIT_BIT = 7;
   localparam int REG33_ON_N_BIT = 0;
   // writable masks: reserved bits read zero
   localparam logic [7:0] BUCK_CFG_MASK = 8'h3f;
   localparam logic [7:0] CORE_VOLT_MASK = 8'h03;
   localparam logic [7:0] REG33_MASK = 8'h81;
   localparam logic [7:0] IRQ_MASK_BITS = 8'h0f;
   // reset values
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] DIMMING_RESET = 8'hff;
   // event bits of the interrupt status register
   localparam int EV_SAMPLE = 0;
   localparam int EV_TEMP = 1;
   localparam int EV_SUPPLY_ALARM = 2;
   localparam int EV_DRIVER_ALARM = 3;
   localparam int NUM_EV = 4;
   // identity value, arbitrary
   localparam logic [7:0] PART_ID_DEFAULT = 8'h5c;
   typedef enum logic [2:0] {
      APB_IDLE = 3'b001,
      APB_SETUP = 3'b010,
      APB_ACCESS = 3'b100
   } pcs_apb_state_t;
endpackage

// >>> verification/tb_pcs_regs.sv
`timescale 1ns/1ps
module tb_pcs_regs;
   import pcs_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b1;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic [1:0] io_peak, core_peak, volt_sel;
   logic io_forced, core_forced, on_n, limit_off;
   logic [2:0] io_zc, core_zc;
   logic sample_strobe = 1'b0;
   logic temp_strobe = 1'b0;
   logic [9:0] smp [6] = '{10'h2a5, 10'h1c3, 10'h3f0, 10'h155, 10'h0aa,
                           10'h301};
   logic [7:0] live [9] = '{8'h12, 8'h81, 8'hd5, 8'h3c, 8'h4d, 8'h5e, 8'h6f,
                            8'h00, 8'h00};
   logic [31:0] rd;
   logic [7:0] d;
   int miscompares = 0;
   int check_count = 0;
   always #4 pclk = ~pclk;
   pcs_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .io_buck_peak_limit(io_peak),
      .io_buck_forced_mode(io_forced), .io_buck_zero_cross_level(io_zc),
      .core_buck_peak_limit(core_peak), .core_buck_forced_mode(core_forced),
      .core_buck_zero_cross_level(core_zc), .core_buck_volt_sel(volt_sel),
      .reg33_on_n(on_n), .reg33_limit_off(limit_off),
      .sample_strobe(sample_strobe), .red_output_batt(smp[0]),
      .green_output_batt(smp[1]), .blue_output_batt(smp[2]),
      .red_output_anode(smp[3]), .green_output_anode(smp[4]),
      .blue_output_anode(smp[5]), .temp_strobe(temp_strobe),
      .temp_low_in(live[0]), .temp_high_in(live[1]),
      .conv_status_in(live[2]), .dimming_in(live[3]),
      .red_headroom_in(live[4]), .green_headroom_in(live[5]),
      .blue_headroom_in(live[6]), .supply_alarm_in(live[7]),
      .driver_alarm_in(live[8]), .irq(irq));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask
   // one idle edge first so psel is never assigned twice in a time step
   task automatic apb(logic wr, logic [7:0] idx, logic [31:0] wd,
                      logic [3:0] st);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         miscompares++;
         print_verdict();
      end else begin
         rd = prdata;
         chk("slave error", 32'h0, {31'h0, pslverr});
         psel <= 1'b0;
         penable <= 1'b0;
         // later checks look at settled outputs, not the launching edge
         @(negedge pclk);
      end
   endtask
   task automatic rchk(string nm, logic [7:0] idx, logic [7:0] exp);
      apb(1'b0, idx, 32'h0, 4'h0);
      chk(nm, {24'h0, exp}, rd);
   endtask
   initial begin
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk("reset outputs", 32'h0, {on_n, limit_off, volt_sel, irq});
      rchk("core voltage reset", IDX_CORE_BUCK_VOLTAGE, 8'h00);
      rchk("anode reset", IDX_RED_ANODE_LOW, 8'h00);
      for (int i = 0; i < 8; i++) begin
         d = {2'b11, 2'(i % 4), 1'(i % 2), 3'(i)};
         apb(1'b1, IDX_IO_BUCK_CONFIG, {24'h0, d}, 4'hf);
         apb(1'b1, IDX_CORE_BUCK_CONFIG, {24'h0, ~d}, 4'hf);
         rchk("io config", IDX_IO_BUCK_CONFIG, d & 8'h3f);
         rchk("core config", IDX_CORE_BUCK_CONFIG, ~d & 8'h3f);
         chk("io fields", {26'h0, d[5:0]},
             {io_peak, io_forced, io_zc});
         chk("core fields", {26'h0, ~d[5:0]},
             {core_peak, core_forced, core_zc});
         apb(1'b1, IDX_CORE_BUCK_VOLTAGE, {24'h0, d}, 4'hf);
         chk("voltage select", 32'(i % 4), {30'h0, volt_sel});
      end
      rchk("core voltage", IDX_CORE_BUCK_VOLTAGE, 8'h03);
      apb(1'b1, IDX_REG33_CONFIG, 32'hff, 4'hf);
      rchk("reg33 config", IDX_REG33_CONFIG, 8'h81);
      chk("reg33 off", 32'h3, {30'h0, on_n, limit_off});
      apb(1'b1, IDX_REG33_CONFIG, 32'h80, 4'hf);
      chk("reg33 on", 32'h1, {30'h0, on_n, limit_off});
      apb(1'b1, IDX_REG33_CONFIG, 32'h01, 4'h0);
      chk("no strobe write", 32'h1, {30'h0, on_n, limit_off});
      apb(1'b1, IDX_IO_BUCK_SPARE, 32'ha5, 4'hf);
      rchk("spare", IDX_IO_BUCK_SPARE, 8'ha5);
      @(posedge pclk);
      clk_en <= 1'b0;
      apb(1'b1, IDX_IO_BUCK_SPARE, 32'h5a, 4'hf);
      @(posedge pclk);
      clk_en <= 1'b1;
      rchk("frozen spare", IDX_IO_BUCK_SPARE, 8'ha5);
      @(posedge pclk);
      sample_strobe <= 1'b1;
      @(posedge pclk);
      sample_strobe <= 1'b0;
      temp_strobe <= 1'b1;
      @(posedge pclk);
      temp_strobe <= 1'b0;
      live[7] <= 8'h01;
      live[8] <= 8'h8c;
      rchk("red battery", IDX_RED_BATT_LOW, smp[0][7:0]);
      rchk("green battery", IDX_GREEN_BATT_LOW, smp[1][7:0]);
      rchk("blue battery", IDX_BLUE_BATT_LOW, smp[2][7:0]);
      rchk("battery high", IDX_BATT_HIGH,
           {2'b00, smp[2][9:8], smp[1][9:8], smp[0][9:8]});
      rchk("red anode", IDX_RED_ANODE_LOW, smp[3][7:0]);
      rchk("green anode", IDX_GREEN_ANODE_LOW, smp[4][7:0]);
      rchk("blue anode", IDX_BLUE_ANODE_LOW, smp[5][7:0]);
      rchk("anode high", IDX_ANODE_HIGH,
           {2'b00, smp[5][9:8], smp[4][9:8], smp[3][9:8]});
      apb(1'b1, IDX_BLUE_ANODE_LOW, 32'h00, 4'hf);
      apb(1'b1, IDX_BATT_HIGH, 32'hff, 4'hf);
      rchk("anode after write", IDX_BLUE_ANODE_LOW, smp[5][7:0]);
      rchk("battery high after write", IDX_BATT_HIGH,
           {2'b00, smp[2][9:8], smp[1][9:8], smp[0][9:8]});
      apb(1'b1, 8'h72, 32'hff, 4'hf);
      rchk("unmapped", 8'h72, 8'h00);
      rchk("temp low", IDX_TEMP_LOW, live[0]);
      rchk("temp high", IDX_TEMP_HIGH, live[1]);
      rchk("conversion", IDX_CONV_STATUS, live[2] & 8'h3f);
      rchk("dimming", IDX_DIMMING, live[3]);
      rchk("red headroom", IDX_RED_HEADROOM, live[4]);
      rchk("green headroom", IDX_GREEN_HEADROOM, live[5]);
      rchk("blue headroom", IDX_BLUE_HEADROOM, live[6]);
      rchk("supply alarm", IDX_SUPPLY_ALARM, 8'h01);
      rchk("driver alarm", IDX_DRIVER_ALARM, 8'h80);
      rchk("identity", IDX_PART_IDENTITY, PART_ID_DEFAULT);
      rchk("irq status", IDX_IRQ_STATUS, 8'h0f);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, IDX_IRQ_MASK, 32'hf4, 4'hf);
      rchk("irq mask", IDX_IRQ_MASK, 8'h04);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1'b1, IDX_IRQ_STATUS, 32'h0f, 4'hf);
      rchk("irq cleared", IDX_IRQ_STATUS, 8'h00);
      chk("irq low", 32'h0, {31'h0, irq});
      // a second reset must return config to its defaults mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk("io config reset", IDX_IO_BUCK_CONFIG, 8'h00);
      chk("reg33 reset", 32'h0, {30'h0, on_n, limit_off});
      print_verdict();
   end
endmodule
